// ==== inc/serial_buf_pkg.sv ====
// shared constants and types for the serial status and data buffer block
package serial_buf_pkg;

  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [7:0] OFF_CONTROL1 = 8'h00;
  localparam logic [7:0] OFF_CONTROL2 = 8'h04;
  localparam logic [7:0] OFF_STATUS   = 8'h08;
  localparam logic [7:0] OFF_DATA     = 8'h0c;

  // ****************************************
  // field positions
  // ****************************************
  localparam int BIT_RX_FULL     = 7;
  localparam int BIT_TX_EMPTY    = 5;
  localparam int BIT_MODE_FAULT  = 4;
  localparam int BIT_RXF_IRQ_EN  = 7;
  localparam int BIT_TX_IRQ_EN   = 5;
  localparam int BIT_MASTER      = 4;
  localparam int BIT_SEL_OUT_EN  = 1;
  localparam int BIT_FAULT_DET   = 4;

  // implemented status bits; the rest read zero
  localparam logic [7:0] STATUS_MASK = 8'hb0;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] RST_CONTROL1 = 8'h00;
  localparam logic [7:0] RST_CONTROL2 = 8'h00;
  localparam logic [7:0] RST_BYTE     = 8'h00;
  localparam logic       RST_TX_EMPTY = 1'b1;

  // ****************************************
  // timing
  // ****************************************
  // cycles from an accepted write on an idle path to the shifter load
  localparam int IDLE_LOAD_CYCLES = 2;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic {SH_IDLE, SH_BUSY} shift_state_t;

  typedef struct packed {
    logic receive_fault_irq_enable;
    logic transmit_irq_enable;
    logic master_select;
    logic select_output_enable;
    logic fault_detect_enable;
  } control_t;

  typedef struct packed {
    logic         ss_s1;
    logic         ss_s2;
    logic [7:0]   ctrl1;
    logic [7:0]   ctrl2;
    logic         receive_full_flag;
    logic         transmit_empty_flag;
    logic         mode_fault_flag;
    logic         arm_rx;
    logic         arm_tx;
    logic         arm_mf;
    logic         tx_full;
    logic [7:0]   tx_buf;
    logic [7:0]   rx_buf;
    shift_state_t sh;
    logic         load;
    logic [7:0]   sh_data;
    logic         pready;
    logic         pslverr;
    logic [31:0]  prdata;
    logic         irq;
  } state_t;

endpackage

// ==== src/serial_buf.sv ====
// status flags, data buffers and apb register slave of the serial port
//
// The implementer's own choices: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// RULE1 - transfer done sets receive full flag
// RULE2 - status read then data read clears it
// RULE3 - transmit empty flag shows buffer room
// RULE4 - status read then data write clears it
// RULE5 - unarmed data write is dropped
// RULE6 - transmit empty with enable raises interrupt
// RULE7 - loading shifter sets transmit empty flag
// RULE8 - idle path loads written byte within two cycles
// RULE9 - queued byte loads when shift ends
// RULE10 - nothing queued: flag stays, no load
// RULE11 - master with select low sets fault
// RULE12 - fault only when master, enabled, no output
// RULE13 - status read then control write clears fault
// RULE14 - data read returns receive buffer
// RULE15 - data write fills transmit buffer
// RULE16 - master transfer starts from buffered write
// RULE17 - software writes only when room exists
// RULE18 - software reads before next transfer ends
// RULE19 - overrun keeps old byte, drops new
// RULE20 - receive full or fault interrupts when enabled
// RULE21 - unimplemented status bits read zero, writes ignored
// RULE22 - overrun leaves no status trace
// RULE23 - reset: flags clear, transmit empty set
module serial_buf
  import serial_buf_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        select_in_n,
  input  wire logic        shifter_done,
  input  wire logic [7:0]  shifter_rx_data,
  output logic             load_shifter,
  output logic      [7:0]  shifter_tx_data,
  output control_t         control,
  output logic             irq
);

  state_t q;
  state_t d;

  logic setup;
  logic access;
  logic rd_status;
  logic rd_data;
  logic wr_data;
  logic wr_ctrl1;
  logic mapped;
  logic fault_cond;
  logic shift_free;
  logic tx_take;
  logic rx_clear;
  logic [7:0] status_val;

  // ****************************************
  // bus decode
  // ****************************************
  assign setup  = psel && !penable && !q.pready;
  assign access = psel && penable && q.pready;
  assign mapped = (paddr == OFF_CONTROL1) || (paddr == OFF_CONTROL2) ||
                  (paddr == OFF_STATUS) || (paddr == OFF_DATA);
  assign rd_status = access && !pwrite && (paddr == OFF_STATUS);
  assign rd_data   = access && !pwrite && (paddr == OFF_DATA);
  assign wr_data   = access && pwrite && (paddr == OFF_DATA);
  assign wr_ctrl1  = access && pwrite && (paddr == OFF_CONTROL1);

  // select input counts as a fault input only in this one setting
  assign fault_cond = q.ctrl1[BIT_MASTER] && q.ctrl2[BIT_FAULT_DET] &&
                      !q.ctrl1[BIT_SEL_OUT_EN]; // RULE12

  assign shift_free = (q.sh == SH_IDLE) || shifter_done;
  assign tx_take    = wr_data && q.arm_tx && q.transmit_empty_flag; // RULE4 RULE5
  assign rx_clear   = rd_data && q.arm_rx; // RULE2

  always_comb begin
    status_val = 8'h00; // RULE21
    status_val[BIT_RX_FULL]    = q.receive_full_flag;
    status_val[BIT_TX_EMPTY]   = q.transmit_empty_flag;
    status_val[BIT_MODE_FAULT] = q.mode_fault_flag;
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    d = q;
    d.load = 1'b0;
    // the first stage feeds only the second
    d.ss_s1 = select_in_n;
    d.ss_s2 = q.ss_s1;

    // apb: answer in the first access cycle, act at its end
    if (setup) begin
      d.pready  = 1'b1;
      d.pslverr = !mapped;
      d.prdata  = 32'h0000_0000;
      if (!pwrite) begin
        case (paddr)
          OFF_CONTROL1: d.prdata = {24'h00_0000, q.ctrl1};
          OFF_CONTROL2: d.prdata = {24'h00_0000, q.ctrl2};
          OFF_STATUS:   d.prdata = {24'h00_0000, status_val};
          OFF_DATA:     d.prdata = {24'h00_0000, q.rx_buf}; // RULE14
          default:      d.prdata = 32'h0000_0000;
        endcase
      end
    end else if (access) begin
      d.pready  = 1'b0;
      d.pslverr = 1'b0;
    end

    // a status read arms the clears from the value it returned
    if (rd_status) begin
      d.arm_rx = q.prdata[BIT_RX_FULL];
      d.arm_tx = q.prdata[BIT_TX_EMPTY];
      d.arm_mf = q.prdata[BIT_MODE_FAULT];
    end

    if (access && pwrite && (paddr == OFF_CONTROL1)) begin
      d.ctrl1 = pwdata[7:0];
    end
    if (access && pwrite && (paddr == OFF_CONTROL2)) begin
      d.ctrl2 = pwdata[7:0];
    end

    // receive side
    if (rx_clear) begin
      d.receive_full_flag = 1'b0; // RULE2
      d.arm_rx = 1'b0;
    end
    if (shifter_done) begin
      // an unread byte stays; overrun has no flag of its own
      if (!q.receive_full_flag || rx_clear) begin // RULE19 RULE22
        d.rx_buf = shifter_rx_data;
        d.receive_full_flag = 1'b1; // RULE1
      end
      d.sh = SH_IDLE;
    end

    // transmit side
    if (wr_data) begin
      d.arm_tx = 1'b0;
    end
    if (tx_take) begin
      d.tx_buf = pwdata[7:0]; // RULE15
      d.tx_full = 1'b1;
      d.transmit_empty_flag = 1'b0; // RULE4
    end
    // loads only from a byte already held, so never clashes with tx_take
    if (q.tx_full && shift_free) begin // RULE8 RULE9
      d.load = 1'b1; // RULE16
      d.sh_data = q.tx_buf;
      d.tx_full = 1'b0;
      d.transmit_empty_flag = 1'b1; // RULE7
      d.sh = SH_BUSY;
    end

    // mode fault; a new fault wins over the clear
    if (wr_ctrl1 && q.arm_mf) begin
      d.mode_fault_flag = 1'b0; // RULE13
      d.arm_mf = 1'b0;
    end
    if (fault_cond && !q.ss_s2) begin
      d.mode_fault_flag = 1'b1; // RULE11
    end

    d.irq = (d.transmit_empty_flag && d.ctrl1[BIT_TX_IRQ_EN]) || // RULE6
            ((d.receive_full_flag || d.mode_fault_flag) &&
             d.ctrl1[BIT_RXF_IRQ_EN]); // RULE20
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q.ss_s1 <= 1'b1;
      q.ss_s2 <= 1'b1;
      q.ctrl1 <= RST_CONTROL1;
      q.ctrl2 <= RST_CONTROL2;
      q.receive_full_flag <= 1'b0; // RULE23
      q.transmit_empty_flag <= RST_TX_EMPTY;
      q.mode_fault_flag <= 1'b0;
      q.arm_rx <= 1'b0;
      q.arm_tx <= 1'b0;
      q.arm_mf <= 1'b0;
      q.tx_full <= 1'b0;
      q.tx_buf <= RST_BYTE;
      q.rx_buf <= RST_BYTE;
      q.sh <= SH_IDLE;
      q.load <= 1'b0;
      q.sh_data <= RST_BYTE;
      q.pready <= 1'b0;
      q.pslverr <= 1'b0;
      q.prdata <= 32'h0000_0000;
      q.irq <= 1'b0;
    end else if (ce) begin
      q <= d;
    end
  end

  assign prdata          = q.prdata;
  assign pready          = q.pready;
  assign pslverr         = q.pslverr;
  assign load_shifter    = q.load;
  assign shifter_tx_data = q.sh_data;
  assign irq             = q.irq;
  assign control.receive_fault_irq_enable = q.ctrl1[BIT_RXF_IRQ_EN];
  assign control.transmit_irq_enable      = q.ctrl1[BIT_TX_IRQ_EN];
  assign control.master_select            = q.ctrl1[BIT_MASTER];
  assign control.select_output_enable     = q.ctrl1[BIT_SEL_OUT_EN];
  assign control.fault_detect_enable      = q.ctrl2[BIT_FAULT_DET];

  // ****************************************
  // assertions
  // ****************************************
  property p_rx_set;
    @(posedge clk) disable iff (rst)
      (ce && shifter_done) |=> q.receive_full_flag;
  endproperty
  a_rx_set: assert property (p_rx_set) else $error("receive full not set"); // RULE1

  property p_rx_clear;
    @(posedge clk) disable iff (rst)
      $fell(q.receive_full_flag) |-> $past(rx_clear && ce);
  endproperty
  a_rx_clear: assert property (p_rx_clear) else $error("receive full cleared wrongly"); // RULE2

  property p_tx_room;
    @(posedge clk) disable iff (rst)
      q.transmit_empty_flag == !q.tx_full;
  endproperty
  a_tx_room: assert property (p_tx_room) else $error("transmit empty disagrees"); // RULE3

  property p_tx_drop;
    @(posedge clk) disable iff (rst)
      (ce && wr_data && !q.arm_tx) |=> ($stable(q.tx_buf) && !$rose(q.tx_full));
  endproperty
  a_tx_drop: assert property (p_tx_drop) else $error("unarmed write taken"); // RULE5

  property p_irq;
    @(posedge clk) disable iff (rst)
      ce |=> q.irq == ((q.transmit_empty_flag && q.ctrl1[BIT_TX_IRQ_EN]) ||
                       ((q.receive_full_flag || q.mode_fault_flag) &&
                        q.ctrl1[BIT_RXF_IRQ_EN]));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt mismatch"); // RULE6

  property p_idle_load;
    @(posedge clk) disable iff (rst)
      (ce && tx_take && q.sh == SH_IDLE && !shifter_done) ##1 ce |=>
        (q.load && q.transmit_empty_flag);
  endproperty
  a_idle_load: assert property (p_idle_load) else $error("idle load late"); // RULE8

  property p_no_load;
    @(posedge clk) disable iff (rst)
      (ce && shifter_done && !q.tx_full && !tx_take) |=>
        (!q.load && q.transmit_empty_flag);
  endproperty
  a_no_load: assert property (p_no_load) else $error("spurious shifter load"); // RULE10

  property p_fault_gate;
    @(posedge clk) disable iff (rst)
      $rose(q.mode_fault_flag) |-> $past(fault_cond && !q.ss_s2);
  endproperty
  a_fault_gate: assert property (p_fault_gate) else $error("fault set out of mode"); // RULE12

  property p_overrun;
    @(posedge clk) disable iff (rst)
      (ce && shifter_done && q.receive_full_flag && !rx_clear) |=>
        ($stable(q.rx_buf) && q.receive_full_flag);
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun replaced byte"); // RULE19

  property p_status_zero;
    @(posedge clk) disable iff (rst)
      (ce && setup && !pwrite && paddr == OFF_STATUS) |=>
        (q.prdata & ~{24'h00_0000, STATUS_MASK}) == 32'h0000_0000;
  endproperty
  a_status_zero: assert property (p_status_zero) else $error("status spare bit set"); // RULE21

  // flags may only clear through the armed access, never through a bare one
  property p_tx_clear;
    @(posedge clk) disable iff (rst)
      $fell(q.transmit_empty_flag) |-> $past(ce && wr_data && q.arm_tx);
  endproperty
  a_tx_clear: assert property (p_tx_clear) else $error("transmit empty cleared wrongly"); // RULE4

  property p_tx_set;
    @(posedge clk) disable iff (rst)
      $rose(q.transmit_empty_flag) |-> q.load;
  endproperty
  a_tx_set: assert property (p_tx_set) else $error("transmit empty set without load"); // RULE7

  property p_queued_load;
    @(posedge clk) disable iff (rst)
      (ce && shifter_done && q.tx_full) |=>
        (q.load && q.transmit_empty_flag && q.sh_data == $past(q.tx_buf));
  endproperty
  a_queued_load: assert property (p_queued_load) else $error("queued byte not loaded"); // RULE9

  property p_fault_set;
    @(posedge clk) disable iff (rst)
      (ce && fault_cond && !q.ss_s2) |=> q.mode_fault_flag;
  endproperty
  a_fault_set: assert property (p_fault_set) else $error("mode fault missed"); // RULE11

  property p_fault_clear;
    @(posedge clk) disable iff (rst)
      $fell(q.mode_fault_flag) |-> $past(ce && wr_ctrl1 && q.arm_mf);
  endproperty
  a_fault_clear: assert property (p_fault_clear) else $error("mode fault cleared wrongly"); // RULE13

  property p_fault_keep;
    @(posedge clk) disable iff (rst)
      (ce && wr_ctrl1 && !q.arm_mf && q.mode_fault_flag) |=> q.mode_fault_flag;
  endproperty
  a_fault_keep: assert property (p_fault_keep) else $error("unarmed control write cleared fault"); // RULE13

  property p_rx_keep;
    @(posedge clk) disable iff (rst)
      (ce && rd_data && !q.arm_rx && q.receive_full_flag) |=> q.receive_full_flag;
  endproperty
  a_rx_keep: assert property (p_rx_keep) else $error("unarmed data read cleared flag"); // RULE2

  property p_rx_data;
    @(posedge clk) disable iff (rst)
      (ce && setup && !pwrite && paddr == OFF_DATA) |=>
        (q.prdata == {24'h00_0000, $past(q.rx_buf)});
  endproperty
  a_rx_data: assert property (p_rx_data) else $error("data read not receive buffer"); // RULE14

  property p_tx_fill;
    @(posedge clk) disable iff (rst)
      (ce && tx_take) |=> (q.tx_full && q.tx_buf == $past(pwdata[7:0]));
  endproperty
  a_tx_fill: assert property (p_tx_fill) else $error("write missed transmit buffer"); // RULE15

  property p_start;
    @(posedge clk) disable iff (rst)
      $rose(q.load) |-> $past(q.tx_full);
  endproperty
  a_start: assert property (p_start) else $error("load without buffered byte"); // RULE16

  // load is a strobe; a held level would start a second shift
  property p_load_pulse;
    @(posedge clk) disable iff (rst)
      (ce && q.load) |=> !q.load;
  endproperty
  a_load_pulse: assert property (p_load_pulse) else $error("load held too long"); // RULE16

  property p_rx_irq;
    @(posedge clk) disable iff (rst)
      ((q.receive_full_flag || q.mode_fault_flag) && q.ctrl1[BIT_RXF_IRQ_EN]) |-> q.irq;
  endproperty
  a_rx_irq: assert property (p_rx_irq) else $error("receive or fault interrupt missing"); // RULE20

  // checked on the first edge after release, while reset itself is not masked
  property p_reset_state;
    @(posedge clk)
      $fell(rst) |-> (!q.receive_full_flag && q.transmit_empty_flag &&
                      !q.mode_fault_flag && !q.tx_full);
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("flags wrong after reset"); // RULE23

endmodule

`default_nettype wire

// ==== verification/shifter_model.sv ====
// behavioural shifter on the far side of the load and done handshake
`timescale 1ns/1ps
`default_nettype none
module shifter_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       load_shifter,
  input  wire logic [7:0] shifter_tx_data,
  input  wire logic [7:0] shift_len,
  output logic            shifter_done,
  output logic      [7:0] shifter_rx_data
);
  logic [7:0] cnt_q;
  logic       busy_q;
  // reply is the inverted sent byte; between pulses the data toggles so stale use shows
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_q          <= 1'b0;
      cnt_q           <= 8'h00;
      shifter_done    <= 1'b0;
      shifter_rx_data <= 8'h00;
    end else begin
      shifter_done    <= 1'b0;
      shifter_rx_data <= ~shifter_rx_data;
      if (load_shifter) begin
        busy_q <= 1'b1;
        cnt_q  <= shift_len;
      end else if (busy_q && cnt_q == 8'h00) begin
        busy_q          <= 1'b0;
        shifter_done    <= 1'b1;
        shifter_rx_data <= ~shifter_tx_data;
      end else if (busy_q) begin
        cnt_q <= cnt_q - 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ==== verification/test_serial_buf.sv ====
// self-checking bench for the serial status and data buffer block
`timescale 1ns/1ps
`default_nettype none
module test_serial_buf
  import serial_buf_pkg::*;
;
  logic        clk = 0, rst = 1, ce = 1, psel = 0, penable = 0, pwrite = 0, select_in_n = 1;
  logic [7:0]  paddr = 8'h00, shift_len = 8'h04, r, e, b1, b3, last_tx;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, irq, load_shifter, shifter_done, err;
  logic [7:0]  shifter_tx_data, shifter_rx_data;
  control_t    control;
  int          errors = 0, n_checks = 0, n_load = 0, n_done = 0;

  serial_buf dut_u (.clk(clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .select_in_n(select_in_n), .shifter_done(shifter_done), .shifter_rx_data(shifter_rx_data),
    .load_shifter(load_shifter), .shifter_tx_data(shifter_tx_data), .control(control), .irq(irq));
  shifter_model far_u (.clk(clk), .rst(rst), .load_shifter(load_shifter), .shifter_tx_data(shifter_tx_data),
    .shift_len(shift_len), .shifter_done(shifter_done), .shifter_rx_data(shifter_rx_data));

  initial begin
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (load_shifter === 1'b1) begin
      n_load++;
      last_tx = shifter_tx_data;
    end
    if (shifter_done === 1'b1) n_done++;
  end

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [7:0] st(input logic rxf, input logic txe, input logic mf);
    return {rxf, 1'b0, txe, mf, 4'h0};
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata[7:0];
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_status(input logic [7:0] exp, input string what);
    apb(1'b0, OFF_STATUS, 8'h00);
    chk(r, exp, what);
  endtask

  // #1 lets the edge's updates land before sampling
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial begin
    void'($urandom(15));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd_status(st(0, 1, 0), "reset status");
    chk({3'h0, control}, 8'h00, "reset control");
    apb(1'b1, OFF_STATUS, 8'hff);
    rd_status(st(0, 1, 0), "status write");
    apb(1'b0, 8'h10, 8'h00);
    chk({7'h0, err}, 8'h01, "unmapped");
    $display("test registers done");
    apb(1'b1, OFF_CONTROL1, 8'h10);
    for (int i = 0; i < 3; i++) begin
      shift_len <= 8'h1e + 8'($urandom_range(20, 0));
      b1 = 8'($urandom);
      b3 = 8'($urandom);
      rd_status(st(0, 1, 0), "idle status");
      apb(1'b1, OFF_DATA, b1);
      cyc(IDLE_LOAD_CYCLES);
      chk(8'(n_load), 8'(2 * i + 1), "idle load");
      chk(last_tx, b1, "shifter byte");
      apb(1'b1, OFF_DATA, ~b1);
      rd_status(st(0, 1, 0), "unarmed write");
      apb(1'b1, OFF_DATA, b3);
      rd_status(st(0, 0, 0), "buffer occupied");
      while (n_done < 2 * i + 2) @(posedge clk);
      cyc(3);
      chk(last_tx, b3, "queued byte");
      chk(8'(n_load), 8'(2 * i + 2), "no extra load");
      apb(1'b0, OFF_DATA, 8'h00);
      chk(r, ~b1, "data read");
      rd_status(st(1, 1, 0), "full, no overrun trace");
      apb(1'b0, OFF_DATA, 8'h00);
      chk(r, ~b1, "old byte kept");
      rd_status(st(0, 1, 0), "receive cleared");
    end
    $display("test transfers done");
    apb(1'b1, OFF_CONTROL1, 8'h30);
    cyc(1);
    chk({7'h0, irq}, 8'h01, "transmit irq");
    chk({3'h0, control}, 8'h0c, "control fields");
    apb(1'b1, OFF_CONTROL1, 8'h90);
    cyc(1);
    chk({7'h0, irq}, 8'h00, "masked irq");
    rd_status(st(0, 1, 0), "arm");
    apb(1'b1, OFF_DATA, 8'h5a);
    while (n_done < 7) @(posedge clk);
    cyc(2);
    chk({7'h0, irq}, 8'h01, "receive irq");
    rd_status(st(1, 1, 0), "full");
    apb(1'b0, OFF_DATA, 8'h00);
    chk(r, 8'ha5, "read before next end");
    cyc(1);
    chk({7'h0, irq}, 8'h00, "irq cleared");
    $display("test irq done");
    for (int m = 0; m < 8; m++) begin
      apb(1'b1, OFF_CONTROL2, {3'h0, m[1], 4'h0});
      apb(1'b1, OFF_CONTROL1, {3'h4, m[0], 2'h0, m[2], 1'b0});
      select_in_n <= 1'b0;
      cyc(6);
      e = st(0, 1, m[0] & m[1] & ~m[2]);
      chk({7'h0, irq}, {7'h0, e[4]}, "fault irq");
      rd_status(e, "fault flag");
      select_in_n <= 1'b1;
      cyc(4);
      apb(1'b1, OFF_CONTROL1, 8'h00);
      rd_status(st(0, 1, 0), "fault cleared");
    end
    // same fault setting as above, but the block is frozen while the select pin is low
    apb(1'b1, OFF_CONTROL2, 8'h10);
    apb(1'b1, OFF_CONTROL1, 8'h10);
    ce <= 1'b0;
    select_in_n <= 1'b0;
    repeat (6) @(posedge clk);
    select_in_n <= 1'b1;
    repeat (3) @(posedge clk);
    ce <= 1'b1;
    rd_status(st(0, 1, 0), "frozen while disabled");
    $display("test fault done");
    test_done;
  end

  initial begin
    #100000;
    errors++;
    $display("BAD t=%0t watchdog expired", $time);
    test_done;
  end
endmodule
`default_nettype wire
